/* File: logic/nic_ctrl.sv */
// nested priority interrupt controller for an 8-bit core
// Summary of operation
// [RULE_01] finish current instruction before entry
// [RULE_02] push pc, x, a and cc on entry
// [RULE_03] load level bits from vector priority
// [RULE_04] load vector after stacking, then fetch
// [RULE_05] return pops registers and restores level
// [RULE_06] highest software priority, ties by hardware
// [RULE_07] unserviced requests stay latched until highest
// [RULE_08] reset and trap rank highest, non-maskable
// [RULE_09] nmi ignores level, sets level 3
// [RULE_10] nmi sources wake from deep stop
// [RULE_11] trap instruction raises software nmi
// [RULE_12] after reset run at level 3
// [RULE_13] maskable needs enable and higher priority
// [RULE_14] external edge latched, cleared on entry
// [RULE_15] selected pins of group are ored
// [RULE_16] peripheral request is flag and enable
// [RULE_17] clearing sequence discards pending latch
// [RULE_18] every source wakes from light sleep
// [RULE_19] deep stop exit serves wake-capable first
// [RULE_20] concurrent never preempts, nested may
// [RULE_21] enable, stop and sleep write 10
// [RULE_22] disable and trap write 11
// [RULE_23] level encoding 10,01,00,11; 11 disables
// [RULE_24] lower vector index wins hardware ties
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`include "nic_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module nic_ctrl
   import nic_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // avalon-mm register slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // interrupt sources
   input  wire logic [13:0] periph_flag,
   input  wire logic [13:0] periph_en,
   input  wire logic [13:0] periph_clr,
   input  wire logic [39:0] ext_pins,
   // core instruction events, one-cycle pulses
   input  wire logic        instr_end,
   input  wire logic        enable_irq_instr,
   input  wire logic        disable_irq_instr,
   input  wire logic        halt_instr,
   input  wire logic        sleep_until_irq_instr,
   input  wire logic        trap_instr,
   input  wire logic        return_from_service_instr,
   input  wire logic        pop_cc_instr,
   input  wire logic [7:0]  pop_cc_value,
   // core register values for stacking
   input  wire logic [15:0] core_pc,
   input  wire logic [7:0]  core_x,
   input  wire logic [7:0]  core_a,
   input  wire logic [3:0]  core_flags,
   // stack memory port
   output logic             stack_wr,
   output logic [7:0]       stack_wdata,
   output logic             stack_rd,
   input  wire logic [7:0]  stack_rdata,
   // core control
   output logic             level_bit_high,
   output logic             level_bit_low,
   output logic             core_hold,
   output logic             core_halted,
   output logic             core_waiting,
   output logic             vec_load,
   output logic [3:0]       vec_index,
   output logic             restore_valid,
   output logic [15:0]      restore_pc,
   output logic [7:0]       restore_x,
   output logic [7:0]       restore_a,
   output logic [3:0]       restore_flags
);

   nic_regs_t r_reg;
   nic_regs_t r_next;

   // level encoding to a rank 0..3
   function automatic logic [1:0] lvl_rank(input logic [1:0] enc);
      case (enc)
         `NIC_LVL0: lvl_rank = 2'h0;  // [RULE_23]
         `NIC_LVL1: lvl_rank = 2'h1;
         `NIC_LVL2: lvl_rank = 2'h2;
         default:   lvl_rank = 2'h3;
      endcase
   endfunction

   // static priority encoder over the pending set, returns
   // {found, vector, encoded level}
   function automatic logic [6:0] arbitrate(input logic [13:0] req,
                                            input logic [31:0] prio);
      logic       found;
      logic [3:0] best;
      logic [1:0] benc;
      logic [1:0] enc;
      found = 1'b0;
      best  = 4'h0;
      benc  = `NIC_LVL0;
      // descending scan with >= lets the lower index win ties
      for (int v = `NIC_NVEC - 1; v >= 0; v--) begin
         enc = prio[2*v +: 2];
         if (req[v] && (!found || lvl_rank(enc) >= lvl_rank(benc))) begin
            found = 1'b1;  // [RULE_06] [RULE_24]
            best  = 4'(v);
            benc  = enc;
         end
      end
      arbitrate = {found, best, benc};
   endfunction

   // combined external group requests
   logic [4:0]  grp_or;
   logic [13:0] ext_vec_mask;
   logic [13:0] periph_req;
   logic [13:0] eligible;
   logic [6:0]  arb;
   logic        mask_ok;
   logic        nmi_any;
   logic        wake_req;
   logic        bus_req;
   logic [7:0]  cc_byte;

   // selected pins of each group are ored into one line
   always_comb begin
      for (int g = 0; g < `NIC_NGRP; g++) begin
         grp_or[g] = |(ext_pins[8*g +: 8] & r_reg.ext_sel[8*g +: 8]);  // [RULE_15]
      end
   end

   assign ext_vec_mask = 14'(5'h1f) << `NIC_EXT_BASE;
   // peripheral lines are level requests of flag and enable
   assign periph_req   = periph_flag & periph_en & ~ext_vec_mask;  // [RULE_16]
   // maskable candidates need their enable bit
   assign eligible     = r_reg.pend & r_reg.vec_en &
                         (r_reg.from_halt ? `NIC_WAKE_MASK : 14'h3fff);  // [RULE_13] [RULE_19]
   assign arb          = arbitrate(eligible, r_reg.prio);
   assign nmi_any      = r_reg.rst_pend | r_reg.trap_pend;
   // concurrent mode serves only when no routine is active
   assign mask_ok      = arb[6] &&
                         lvl_rank(arb[1:0]) > lvl_rank(r_reg.level) &&
                         (r_reg.nested || r_reg.depth == 4'h0);  // [RULE_13] [RULE_20]
   assign wake_req     = |(r_reg.pend & r_reg.vec_en & `NIC_WAKE_MASK);
   assign bus_req      = read | write;
   assign cc_byte      = {2'b11, r_reg.level[1], core_flags[3],
                          r_reg.level[0], core_flags[2:0]};

   always_comb begin
      r_next = r_reg;
      r_next.stack_wr      = 1'b0;
      r_next.stack_rd      = 1'b0;
      r_next.vec_load      = 1'b0;
      r_next.restore_valid = 1'b0;

      // pending latches; the clearing sequence wins over a new set
      r_next.grp_prev = grp_or;
      for (int v = 0; v < `NIC_NVEC; v++) begin
         if (ext_vec_mask[v]) begin
            if (grp_or[v - `NIC_EXT_BASE] && !r_reg.grp_prev[v - `NIC_EXT_BASE])
               r_next.pend[v] = 1'b1;  // [RULE_14] [RULE_07]
         end else if (periph_clr[v]) begin
            r_next.pend[v] = 1'b0;  // [RULE_17]
         end else if (periph_req[v]) begin
            r_next.pend[v] = 1'b1;  // [RULE_07]
         end
      end
      if (trap_instr)
         r_next.trap_pend = 1'b1;  // [RULE_11]

      // level-changing instructions
      if (enable_irq_instr || halt_instr || sleep_until_irq_instr)
         r_next.level = `NIC_LVL0;  // [RULE_21]
      if (disable_irq_instr || trap_instr)
         r_next.level = `NIC_LVL3;  // [RULE_22]
      if (pop_cc_instr)
         r_next.level = {pop_cc_value[5], pop_cc_value[3]};
      if (halt_instr)
         r_next.halted = 1'b1;
      if (sleep_until_irq_instr)
         r_next.waiting = 1'b1;

      // wake-up: deep stop only on wake-capable or nmi sources
      if (r_reg.halted && (wake_req || nmi_any)) begin
         r_next.halted    = 1'b0;  // [RULE_10] [RULE_19]
         r_next.from_halt = 1'b1;
      end
      if (r_reg.waiting && (|(r_reg.pend & r_reg.vec_en) || nmi_any))
         r_next.waiting = 1'b0;  // [RULE_18]

      case (r_reg.st)
         NIC_IDLE: begin
            // reset entry skips stacking and the instruction boundary
            if (r_reg.rst_pend) begin
               r_next.rst_pend  = 1'b0;
               r_next.sel_vec   = `NIC_VEC_RESET;
               r_next.sel_nmi   = 1'b1;
               r_next.sel_level = `NIC_LVL3;  // [RULE_12]
               r_next.core_hold = 1'b1;
               r_next.st        = NIC_VECT;
            end else if (return_from_service_instr) begin
               r_next.core_hold = 1'b1;
               r_next.cnt       = 3'h0;
               r_next.st        = NIC_POP;  // [RULE_05]
            end else if (!r_reg.halted &&
                         (r_reg.trap_pend || mask_ok)) begin
               // nmi ranks above every maskable level
               r_next.sel_nmi   = r_reg.trap_pend;  // [RULE_08] [RULE_09]
               r_next.sel_vec   = r_reg.trap_pend ? `NIC_VEC_TRAP
                                                  : arb[5:2];
               r_next.sel_level = r_reg.trap_pend ? `NIC_LVL3
                                                  : arb[1:0];  // [RULE_09]
               r_next.st        = NIC_WEND;
            end
         end
         NIC_WEND: begin
            // suspend at the end of the running instruction, or at once while waiting
            if (instr_end || r_reg.waiting) begin
               r_next.core_hold = 1'b1;  // [RULE_01]
               r_next.waiting   = 1'b0;
               r_next.cnt       = 3'h0;
               r_next.st        = NIC_PUSH;
            end
         end
         NIC_PUSH: begin
            // push order pcl, pch, x, a, cc; cc holds the old level
            r_next.stack_wr = 1'b1;  // [RULE_02]
            case (r_reg.cnt)
               3'h0:    r_next.stack_wdata = core_pc[7:0];
               3'h1:    r_next.stack_wdata = core_pc[15:8];
               3'h2:    r_next.stack_wdata = core_x;
               3'h3:    r_next.stack_wdata = core_a;
               default: r_next.stack_wdata = cc_byte;
            endcase
            r_next.cnt = r_reg.cnt + 3'h1;
            if (r_reg.cnt == `NIC_NSTACK - 3'h1)
               r_next.st = NIC_VECT;
         end
         NIC_VECT: begin
            // level loaded and vector handed to the core fetch in the same cycle
            r_next.level     = r_reg.sel_level;  // [RULE_03] [RULE_09]
            r_next.vec_load  = 1'b1;  // [RULE_04]
            r_next.vec_index = r_reg.sel_vec;
            r_next.core_hold = 1'b0;
            r_next.from_halt = 1'b0;
            if (r_reg.sel_nmi) begin
               if (r_reg.sel_vec == `NIC_VEC_TRAP)
                  r_next.trap_pend = trap_instr;
            end else begin
               // edge latches clear on entry; peripherals stay level
               if (ext_vec_mask[r_reg.sel_vec])
                  r_next.pend[r_reg.sel_vec] =  // [RULE_14]
                     grp_or[3'(r_reg.sel_vec - 4'h4)] &&
                     !r_reg.grp_prev[3'(r_reg.sel_vec - 4'h4)];
            end
            if (r_reg.sel_vec != `NIC_VEC_RESET &&
                r_reg.depth != 4'hf)
               r_next.depth = r_reg.depth + 4'h1;
            r_next.st = NIC_IDLE;
         end
         NIC_POP: begin
            // read one byte a cycle; data is valid a cycle later
            r_next.stack_rd = (r_reg.cnt < `NIC_NSTACK);
            if (r_reg.stack_rd) begin
               case (r_reg.cnt)
                  3'h1: begin
                     r_next.level = {stack_rdata[5], stack_rdata[3]};  // [RULE_05]
                     r_next.restore_flags = {stack_rdata[4],
                                             stack_rdata[2:0]};
                  end
                  3'h2:    r_next.restore_a         = stack_rdata;
                  3'h3:    r_next.restore_x         = stack_rdata;
                  3'h4:    r_next.restore_pc[15:8]  = stack_rdata;
                  default: r_next.restore_pc[7:0]   = stack_rdata;
               endcase
            end
            r_next.cnt = r_reg.cnt + 3'h1;
            if (r_reg.cnt == `NIC_NSTACK) begin
               r_next.restore_valid = 1'b1;
               r_next.core_hold     = 1'b0;
               if (r_reg.depth != 4'h0)
                  r_next.depth = r_reg.depth - 4'h1;
               r_next.st = NIC_IDLE;
            end
         end
         default: r_next.st = NIC_IDLE;
      endcase

      // register slave: one wait cycle, answer on the second
      r_next.waitreq = ~(bus_req & r_reg.waitreq);
      if (read && r_reg.waitreq) begin
         case (address)
            `NIC_IDX_PRIO0:  r_next.rdata = {24'h0, r_reg.prio[7:0]};
            `NIC_IDX_PRIO1:  r_next.rdata = {24'h0, r_reg.prio[15:8]};
            `NIC_IDX_PRIO2:  r_next.rdata = {24'h0, r_reg.prio[23:16]};
            `NIC_IDX_PRIO3:  r_next.rdata = {24'h0, `NIC_PRIO3_FIXED,
                                             r_reg.prio[27:24]};
            `NIC_IDX_VEC_EN: r_next.rdata = {18'h0, r_reg.vec_en};
            `NIC_IDX_CTRL:   r_next.rdata = {31'h0, r_reg.nested};
            `NIC_IDX_STATUS: r_next.rdata = {16'h0, r_reg.depth,
                                             r_reg.sel_vec, 1'b0,
                                             r_reg.st, r_reg.halted,
                                             r_reg.waiting,
                                             r_reg.level};
            `NIC_IDX_PEND:   r_next.rdata = {17'h0, r_reg.trap_pend,
                                             r_reg.pend};
            default: begin
               if (address >= `NIC_IDX_EXTSEL0 &&
                   address <= `NIC_IDX_EXTSEL4)
                  r_next.rdata = {24'h0, r_reg.ext_sel[
                     8*(address - `NIC_IDX_EXTSEL0) +: 8]};
               else
                  r_next.rdata = 32'h0;
            end
         endcase
      end
      if (write && !r_reg.waitreq) begin
         case (address)
            `NIC_IDX_PRIO0:  r_next.prio[7:0]   = writedata[7:0];
            `NIC_IDX_PRIO1:  r_next.prio[15:8]  = writedata[7:0];
            `NIC_IDX_PRIO2:  r_next.prio[23:16] = writedata[7:0];
            `NIC_IDX_PRIO3:  r_next.prio[27:24] = writedata[3:0];
            `NIC_IDX_VEC_EN: r_next.vec_en      = writedata[13:0];
            `NIC_IDX_CTRL:   r_next.nested      = writedata[`NIC_CTRL_NESTED];
            default: begin
               if (address >= `NIC_IDX_EXTSEL0 &&
                   address <= `NIC_IDX_EXTSEL4)
                  r_next.ext_sel[8*(address - `NIC_IDX_EXTSEL0) +: 8] =
                     writedata[7:0];
            end
         endcase
      end
   end

   // one register bank for the whole block
   always_ff @(posedge clk) begin
      if (!rstn) begin
         r_reg           <= '0;
         r_reg.st        <= NIC_IDLE;
         r_reg.level     <= `NIC_LVL3;  // [RULE_12]
         r_reg.prio      <= `NIC_PRIO_RST;
         r_reg.vec_en    <= `NIC_VEC_EN_RST;
         r_reg.rst_pend  <= 1'b1;  // [RULE_08]
         r_reg.core_hold <= 1'b1;
         r_reg.waitreq   <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // outputs straight from the register bank
   assign readdata       = r_reg.rdata;
   assign waitrequest    = r_reg.waitreq;
   assign stack_wr       = r_reg.stack_wr;
   assign stack_wdata    = r_reg.stack_wdata;
   assign stack_rd       = r_reg.stack_rd;
   assign level_bit_high = r_reg.level[1];
   assign level_bit_low  = r_reg.level[0];
   assign core_hold      = r_reg.core_hold;
   assign core_halted    = r_reg.halted;
   assign core_waiting   = r_reg.waiting;
   assign vec_load       = r_reg.vec_load;
   assign vec_index      = r_reg.vec_index;
   assign restore_valid  = r_reg.restore_valid;
   assign restore_pc     = r_reg.restore_pc;
   assign restore_x      = r_reg.restore_x;
   assign restore_a      = r_reg.restore_a;
   assign restore_flags  = r_reg.restore_flags;

endmodule // nic_ctrl

`default_nettype wire

/* File: pkg/nic_defines.svh */
// offsets, field positions, reset values and counts of the interrupt block
`ifndef NIC_DEFINES_SVH
`define NIC_DEFINES_SVH

// register word indexes; byte address is four times the index
`define NIC_IDX_PRIO0   4'h0
`define NIC_IDX_PRIO1   4'h1
`define NIC_IDX_PRIO2   4'h2
`define NIC_IDX_PRIO3   4'h3
`define NIC_IDX_VEC_EN  4'h4
`define NIC_IDX_EXTSEL0 4'h5
`define NIC_IDX_EXTSEL4 4'h9
`define NIC_IDX_CTRL    4'ha
`define NIC_IDX_STATUS  4'hb
`define NIC_IDX_PEND    4'hc

// vector counts and external groups
`define NIC_NVEC        14
`define NIC_NGRP        5
`define NIC_EXT_BASE    4
`define NIC_NSTACK      3'h5

// level encodings of the two current-level bits
`define NIC_LVL0        2'h2
`define NIC_LVL1        2'h1
`define NIC_LVL2        2'h0
`define NIC_LVL3        2'h3

// reset values, fixed priority bits and wake mask
`define NIC_PRIO_RST    32'hffffffff
`define NIC_PRIO3_FIXED 4'hf
`define NIC_VEC_EN_RST  14'h0000
`define NIC_WAKE_MASK   14'h03f4

// vector numbers of the non-maskable sources
`define NIC_VEC_RESET   4'hf
`define NIC_VEC_TRAP    4'he

// control bit
`define NIC_CTRL_NESTED 0

`endif

/* File: pkg/nic_pkg.sv */
// types of the nested priority interrupt controller
package nic_pkg;

   typedef enum logic [2:0] {
      NIC_IDLE  = 3'b000,
      NIC_WEND  = 3'b001,
      NIC_PUSH  = 3'b010,
      NIC_VECT  = 3'b011,
      NIC_POP   = 3'b100
   } nic_state_t;

   typedef struct packed {
      nic_state_t  st;
      logic [2:0]  cnt;
      logic [1:0]  level;
      logic [31:0] prio;
      logic [13:0] vec_en;
      logic [39:0] ext_sel;
      logic        nested;
      logic [13:0] pend;
      logic [4:0]  grp_prev;
      logic        trap_pend;
      logic        rst_pend;
      logic        halted;
      logic        waiting;
      logic        from_halt;
      logic [3:0]  depth;
      logic [3:0]  sel_vec;
      logic        sel_nmi;
      logic [1:0]  sel_level;
      logic        stack_wr;
      logic [7:0]  stack_wdata;
      logic        stack_rd;
      logic        vec_load;
      logic [3:0]  vec_index;
      logic        core_hold;
      logic        restore_valid;
      logic [15:0] restore_pc;
      logic [7:0]  restore_x;
      logic [7:0]  restore_a;
      logic [3:0]  restore_flags;
      logic        waitreq;
      logic [31:0] rdata;
   } nic_regs_t;

endpackage

/* File: tb/nic_core_model.sv */
// core pacing and stack memory model
`timescale 1ns/100ps
`default_nettype none

module nic_core_model
   import nic_pkg::*;
#(
   parameter int GAP = 4   // cycles between instruction ends
)
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // stack port
   input  wire logic       stack_wr,
   input  wire logic [7:0] stack_wdata,
   input  wire logic       stack_rd,
   output logic [7:0]      stack_rdata,
   // instruction pacing
   input  wire logic       core_hold,
   output logic            instr_end
);
   logic [7:0] mem [256];
   logic [7:0] sp;
   int         cnt;

   // a held core ends no instruction
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt <= 0;
         instr_end <= 1'b0;
         sp <= 8'h00;
      end else begin
         cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
         instr_end <= (cnt == GAP - 1) && !core_hold;
         if (stack_wr) begin
            mem[sp] <= stack_wdata;
            sp <= sp + 8'h01;
         end
         if (stack_rd)
            sp <= sp - 8'h01;
      end
   end

   // byte stands while stack_rd is high, taken at its closing edge
   assign stack_rdata = stack_rd ? mem[sp - 8'h01] : 8'h00;
endmodule // nic_core_model
`default_nettype wire

/* File: tb/nic_ctrl_asserts.sv */
// port checker of the nested priority interrupt controller
`timescale 1ns/100ps
`default_nettype none

module nic_ctrl_asserts
   import nic_pkg::*;
(
   // clock and reset
   input wire logic       clk,
   input wire logic       rstn,
   // register bus
   input wire logic       read,
   input wire logic       write,
   input wire logic       waitrequest,
   // core events
   input wire logic       instr_end,
   input wire logic       enable_irq_instr,
   input wire logic       disable_irq_instr,
   input wire logic       halt_instr,
   input wire logic       sleep_until_irq_instr,
   input wire logic       trap_instr,
   input wire logic       return_from_service_instr,
   // core side outputs
   input wire logic       stack_wr,
   input wire logic       stack_rd,
   input wire logic       level_bit_high,
   input wire logic       level_bit_low,
   input wire logic       core_hold,
   input wire logic       vec_load,
   input wire logic [3:0] vec_index,
   input wire logic       restore_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // level writes to 10 outside entry and return
   logic lvl_open;
   assign lvl_open = (enable_irq_instr | halt_instr | sleep_until_irq_instr)
                     & !core_hold;

   AST_WAIT_ONE: assert property ((read | write) && waitrequest |=>
      !waitrequest) else $error("no answer in one cycle");
   AST_WAIT_PULSE: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low too long");
   AST_ENTRY_STACK: assert property (
      $rose(stack_wr) |-> stack_wr [*5] ##1
      (vec_load && !core_hold)) else $error("entry sequence broken");
   AST_ENTRY_AFTER_END: assert property (
      $rose(stack_wr) |-> $past(instr_end, 2))
      else $error("entry inside an instruction");
   AST_NMI_LEVEL: assert property (
      vec_load && vec_index[3:1] == 3'h7 |-> level_bit_high && level_bit_low)
      else $error("non-maskable entry not at level 3");
   AST_LEVEL_OPEN: assert property (
      lvl_open |=> level_bit_high && !level_bit_low)
      else $error("level not opened to 10");
   AST_LEVEL_SHUT: assert property (
      (disable_irq_instr | trap_instr) && !core_hold |=>
      level_bit_high && level_bit_low) else $error("level not shut to 11");
   AST_RETURN_SEQ: assert property (
      return_from_service_instr && !core_hold |=> core_hold && !stack_rd
      ##1 stack_rd [*5] ##1 (restore_valid && !core_hold))
      else $error("return sequence broken");

   // main scenarios reached
   cover property ($rose(stack_wr));
   cover property (vec_load && vec_index == 4'he);
   cover property (restore_valid);
endmodule // nic_ctrl_asserts

bind nic_ctrl nic_ctrl_asserts u_asserts (.clk(clk), .rstn(rstn),
   .read(read), .write(write), .waitrequest(waitrequest),
   .instr_end(instr_end), .enable_irq_instr(enable_irq_instr),
   .disable_irq_instr(disable_irq_instr), .halt_instr(halt_instr),
   .sleep_until_irq_instr(sleep_until_irq_instr), .trap_instr(trap_instr),
   .return_from_service_instr(return_from_service_instr),
   .stack_wr(stack_wr), .stack_rd(stack_rd),
   .level_bit_high(level_bit_high), .level_bit_low(level_bit_low),
   .core_hold(core_hold), .vec_load(vec_load), .vec_index(vec_index),
   .restore_valid(restore_valid));
`default_nettype wire

/* File: tb/nic_ctrl_tb_top.sv */
// self-checking bench of the interrupt controller
`timescale 1ns/100ps
`default_nettype none

module nic_ctrl_tb_top;
   import nic_pkg::*;
   typedef struct {logic [31:0] p; logic [13:0] en, f; logic [3:0] v;
      logic [1:0] l;} nic_row_t;
   logic        clk, rstn, read, write, waitrequest, instr_end;
   logic        stack_wr, stack_rd, core_hold, vec_load, restore_valid;
   logic        level_bit_high, level_bit_low;
   logic [3:0]  address, vec_index, restore_flags, v;
   logic [31:0] writedata, readdata, q;
   logic [13:0] periph_flag, periph_clr;
   logic [39:0] ext_pins;
   logic [6:0]  ev;
   logic [15:0] core_pc, restore_pc;
   logic [7:0]  stack_wdata, stack_rdata;
   logic [1:0]  l;
   int          num_errors = 0;
   int          compares = 0;
   // priority bytes, enables, flags, expected vector and level
   nic_row_t rows [4] = '{
      '{32'h000000c0, 14'h3fff, 14'h000a, 4'h3, 2'h3},
      '{32'h00000000, 14'h3fff, 14'h0402, 4'h1, 2'h0},
      '{32'h00100000, 14'h3fff, 14'h0c00, 4'hb, 2'h0},
      '{32'h00000000, 14'h1000, 14'h1001, 4'hc, 2'h0}};

   nic_ctrl dut (.clk(clk), .rstn(rstn), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .periph_flag(periph_flag),
      .periph_en(14'h3fff), .periph_clr(periph_clr), .ext_pins(ext_pins),
      .instr_end(instr_end), .enable_irq_instr(ev[0]),
      .disable_irq_instr(ev[1]), .halt_instr(ev[2]),
      .sleep_until_irq_instr(ev[3]), .trap_instr(ev[4]),
      .return_from_service_instr(ev[5]), .pop_cc_instr(ev[6]),
      .pop_cc_value(8'h00), .core_pc(core_pc), .core_x(8'h5a),
      .core_a(8'ha5), .core_flags(4'h9), .stack_wr(stack_wr),
      .stack_wdata(stack_wdata), .stack_rd(stack_rd),
      .stack_rdata(stack_rdata), .level_bit_high(level_bit_high),
      .level_bit_low(level_bit_low), .core_hold(core_hold),
      .core_halted(), .core_waiting(), .vec_load(vec_load),
      .vec_index(vec_index), .restore_valid(restore_valid),
      .restore_pc(restore_pc), .restore_x(), .restore_a(),
      .restore_flags(restore_flags));
   nic_core_model u_core (.clk(clk), .rstn(rstn), .stack_wr(stack_wr),
      .stack_wdata(stack_wdata), .stack_rd(stack_rd),
      .stack_rdata(stack_rdata), .core_hold(core_hold),
      .instr_end(instr_end));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic end_sim;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
   endtask

   // bounded wait for a level
   task automatic wfor(ref logic s, input logic lv);
      for (int n = 0; n < 100 && s !== lv; n++) @(negedge clk);
      if (s !== lv) begin
         num_errors++;
         end_sim();
      end
   endtask

   // one avalon access held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input [31:0] d);
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= !w;
      write <= w;
      wfor(waitrequest, 1'b0);
      @(posedge clk);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic evp(input int k);
      @(posedge clk);
      ev <= 7'h01 << k;
      @(posedge clk);
      ev <= 7'h00;
   endtask

   task automatic wvec;
      wfor(vec_load, 1'b1);
      v = vec_index;
      l = {level_bit_high, level_bit_low};
   endtask

   task automatic quiet;
      int n;
      n = 0;
      repeat (16) begin @(negedge clk); if (vec_load === 1'b1) n++; end
      chk("no entry", n, 0);
   endtask

   task automatic ret(input logic [1:0] el);
      evp(5);
      wfor(restore_valid, 1'b1);
      chk("restore pc", restore_pc, core_pc);
      chk("restore flags", restore_flags, 4'h9);
      chk("restore level", {level_bit_high, level_bit_low}, el);
   endtask

   initial begin
      {rstn, read, write, address, writedata, ev} = '0;
      {periph_flag, periph_clr, ext_pins} = '0;
      core_pc = 16'h1000;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      wvec();
      chk("reset vector", v, 4'hf);
      chk("reset level", l, 2'h3);
      bus(1'b0, 4'h0, 32'h0);
      chk("prio0 reset", q, 32'hff);
      bus(1'b0, 4'hd, 32'h0);
      chk("unmapped read", q, 32'h0);
      // arbitration table; each request first waits masked at level 3
      foreach (rows[r]) begin
         for (int i = 0; i < 4; i++) bus(1'b1, 4'(i), rows[r].p[8*i +: 8]);
         bus(1'b1, 4'h4, {18'h0, rows[r].en});
         evp(1);
         core_pc <= 16'h1000 + 16'(r);
         periph_flag <= rows[r].f;
         quiet();
         evp(0);
         wvec();
         chk("vector", v, rows[r].v);
         chk("entry level", l, rows[r].l);
         periph_flag <= 14'h0;
         periph_clr <= rows[r].f;
         @(posedge clk);
         periph_clr <= 14'h0;
         ret(2'h2);
      end
      // software trap at level 10
      core_pc <= 16'h2000;
      evp(4);
      wvec();
      chk("trap vector", v, 4'he);
      chk("trap level", l, 2'h3);
      ret(2'h3);
      // external group 0 with pins 0 and 1 selected, vector at level 1
      bus(1'b1, 4'h5, 32'h03);
      bus(1'b1, 4'h1, 32'h01);
      bus(1'b1, 4'h4, 32'h3fff);
      ext_pins <= 40'h4;
      evp(0);
      quiet();
      ext_pins <= 40'h6;
      wvec();
      chk("group vector", v, 4'h4);
      chk("group level", l, 2'h1);
      ret(2'h2);
      quiet();
      ext_pins <= 40'h0;
      // clearing sequence drops a masked pending request
      evp(1);
      periph_flag <= 14'h0200;
      repeat (4) @(posedge clk);
      bus(1'b0, 4'hc, 32'h0);
      chk("pending held", q, 32'h0200);
      periph_flag <= 14'h0;
      periph_clr <= 14'h0200;
      @(posedge clk);
      periph_clr <= 14'h0;
      bus(1'b0, 4'hc, 32'h0);
      chk("pending dropped", q, 32'h0);
      evp(0);
      quiet();
      end_sim();
   end
endmodule // nic_ctrl_tb_top
`default_nettype wire
